// >>> rtl/wsq_pkg.sv
`default_nettype none

package wsq_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int WGT_W = 24;
    localparam int CNT_W = 16;
    localparam int JCNT_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FINAL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SP1 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SP2 = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CPS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_OVER = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_UNDER = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_NEAR = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_INHIB_T = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_JUDGE_T = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_CMPL_T = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_ADJ_T = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_JCOUNT = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h34;

    // Control register fields
    localparam int CTRL_SEQ = 0;
    localparam int CTRL_NZ_NET = 1;
    localparam int CTRL_CMP_NET = 2;
    localparam int CTRL_ADJ_EN = 3;
    localparam int CTRL_OU_HELD = 4;
    localparam int CTRL_CMPL_FAST = 5;
    localparam int CTRL_W = 6;

    // Status register fields
    localparam int STAT_GATES = 0;
    localparam int STAT_NZ = 3;
    localparam int STAT_JUDGE = 4;
    localparam int STAT_CMPL = 7;
    localparam int STAT_ADJ = 8;
    localparam int STAT_ERR = 9;
    localparam int STAT_STATE = 12;

    // Reset values and the no-judgment count
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    localparam logic [JCNT_W-1:0] JCOUNT_RST = 8'h01;
    localparam logic [JCNT_W-1:0] JCOUNT_NONE = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FEED = 3'b001,
        ST_JUDGE = 3'b010,
        ST_CMPL = 3'b011,
        ST_ADJ = 3'b100,
        ST_REARM = 3'b101,
        ST_ERR = 3'b110
    } wsq_state_t;

    typedef struct packed {
        logic first;
        logic second;
        logic final_g;
    } wsq_gates_t;

    typedef struct packed {
        logic over;
        logic go;
        logic under;
    } wsq_judge_t;

endpackage : wsq_pkg

`default_nettype wire

// >>> rtl/wsq_sequencer.sv
`default_nettype none

module wsq_sequencer #(
    parameter int WGT_W = wsq_pkg::WGT_W,
    parameter int CNT_W = wsq_pkg::CNT_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [wsq_pkg::ADDR_W-1:0] addr,
    input wire logic [wsq_pkg::DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [wsq_pkg::DATA_W-1:0] rdata,
    input wire logic [WGT_W-1:0] gross_weight,
    input wire logic [WGT_W-1:0] net_weight,
    input wire logic start_in,
    input wire logic stop_in,
    output logic first_gate_output,
    output logic second_gate_output,
    output logic final_gate_output,
    output logic near_empty_flag,
    output logic over_out,
    output logic go_out,
    output logic under_out,
    output logic complete_out,
    output logic adjust_out,
    output logic seq_error
);

    if (WGT_W < 8 || WGT_W > wsq_pkg::DATA_W - 1) begin : g_bad_wgt
        $error("WGT_W out of range");
    end
    if (CNT_W < 2 || CNT_W > wsq_pkg::DATA_W) begin : g_bad_cnt
        $error("CNT_W out of range");
    end

    typedef struct packed {
        logic [wsq_pkg::CTRL_W-1:0] ctrl;
        logic [WGT_W-1:0] fin;
        logic [WGT_W-1:0] sp1;
        logic [WGT_W-1:0] sp2;
        logic [WGT_W-1:0] fall_compensation_value;
        logic [WGT_W-1:0] ovr;
        logic [WGT_W-1:0] und;
        logic [WGT_W-1:0] nzl;
        logic [CNT_W-1:0] inhib_t;
        logic [CNT_W-1:0] judge_t;
        logic [CNT_W-1:0] cmpl_t;
        logic [CNT_W-1:0] adj_t;
        logic [wsq_pkg::JCNT_W-1:0] jcount;
        wsq_pkg::wsq_state_t st;
        wsq_pkg::wsq_gates_t gates;
        wsq_pkg::wsq_judge_t judge;
        logic nz;
        logic cmpl;
        logic adj;
        logic err;
        logic start_d;
        logic stop_d;
        logic [CNT_W-1:0] tmr;
        logic [CNT_W-1:0] inhib;
        logic [WGT_W-1:0] held;
        logic [wsq_pkg::DATA_W-1:0] rdata;
    } wsq_regs_t;

    localparam wsq_regs_t R_RST = '{
        ctrl: wsq_pkg::CTRL_RST,
        jcount: wsq_pkg::JCOUNT_RST,
        st: wsq_pkg::ST_IDLE,
        default: '0
    };

    function automatic logic signed [WGT_W:0] sx(input logic [WGT_W-1:0] v);
        sx = $signed({v[WGT_W-1], v});
    endfunction : sx

    function automatic wsq_pkg::wsq_judge_t judge_of(
        input logic signed [WGT_W:0] v,
        input logic signed [WGT_W:0] lim_over,
        input logic signed [WGT_W:0] lim_under
    );
        judge_of.over = v > lim_over;
        judge_of.under = v <= lim_under;
        judge_of.go = (v <= lim_over) && (v >= lim_under);
    endfunction : judge_of

    logic [1:0] rst_sync_r;
    logic rst_sync_n;
    wsq_regs_t r;
    wsq_regs_t n;

    // Async assert, synchronous release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_r[1];

    logic signed [WGT_W:0] cw_x;
    logic signed [WGT_W:0] nzw_x;
    logic signed [WGT_W:0] thr1;
    logic signed [WGT_W:0] thr2;
    logic signed [WGT_W:0] thr3;
    logic signed [WGT_W:0] lim_over;
    logic signed [WGT_W:0] lim_under;
    logic signed [WGT_W+2:0] cw4;
    logic signed [WGT_W+2:0] fin_w;
    logic hit1;
    logic hit2;
    logic hit3;
    logic below_quarter;
    logic judge_none;
    logic start_rise;
    logic stop_rise;
    logic tdone;
    logic seq_mode;

    assign seq_mode = r.ctrl[wsq_pkg::CTRL_SEQ];
    assign cw_x = r.ctrl[wsq_pkg::CTRL_CMP_NET] ? sx(net_weight) : sx(gross_weight);
    assign nzw_x = r.ctrl[wsq_pkg::CTRL_NZ_NET] ? sx(net_weight) : sx(gross_weight);
    assign thr1 = sx(r.fin) - sx(r.sp1);
    assign thr2 = sx(r.fin) - sx(r.sp2);
    assign thr3 = sx(r.fin) - sx(r.fall_compensation_value);
    assign lim_over = sx(r.fin) + sx(r.ovr);
    assign lim_under = sx(r.fin) - sx(r.und);
    assign hit1 = cw_x >= thr1;
    assign hit2 = cw_x >= thr2;
    assign hit3 = cw_x >= thr3;
    // Compare 4*w with final, avoiding a rounding division
    assign cw4 = {cw_x, 2'b00};
    assign fin_w = {{2{r.fin[WGT_W-1]}}, sx(r.fin)};
    assign below_quarter = cw4 < fin_w;
    assign judge_none = r.jcount == wsq_pkg::JCOUNT_NONE;
    assign start_rise = start_in && !r.start_d;
    assign stop_rise = stop_in && !r.stop_d;
    // Timers load T at entry; leaving at 1 gives T cycles, at least one
    assign tdone = r.tmr <= CNT_W'(1);

    always_comb begin
        n = r;
        n.start_d = start_in;
        n.stop_d = stop_in;
        n.rdata = '0;
        n.nz = nzw_x <= sx(r.nzl);
        if (r.inhib != '0) begin
            n.inhib = r.inhib - CNT_W'(1);
        end
        if (r.tmr != '0) begin
            n.tmr = r.tmr - CNT_W'(1);
        end

        if (wr_stb) begin
            if (addr == wsq_pkg::OFS_CTRL) begin
                n.ctrl = wdata[wsq_pkg::CTRL_W-1:0];
            end else if (addr == wsq_pkg::OFS_FINAL) begin
                n.fin = wdata[WGT_W-1:0];
            end else if (addr == wsq_pkg::OFS_SP1) begin
                n.sp1 = wdata[WGT_W-1:0];
            end else if (addr == wsq_pkg::OFS_SP2) begin
                n.sp2 = wdata[WGT_W-1:0];
            end else if (addr == wsq_pkg::OFS_CPS) begin
                n.fall_compensation_value = wdata[WGT_W-1:0];
            end else if (addr == wsq_pkg::OFS_OVER) begin
                n.ovr = wdata[WGT_W-1:0];
            end else if (addr == wsq_pkg::OFS_UNDER) begin
                n.und = wdata[WGT_W-1:0];
            end else if (addr == wsq_pkg::OFS_NEAR) begin
                n.nzl = wdata[WGT_W-1:0];
            end else if (addr == wsq_pkg::OFS_INHIB_T) begin
                n.inhib_t = wdata[CNT_W-1:0];
            end else if (addr == wsq_pkg::OFS_JUDGE_T) begin
                n.judge_t = wdata[CNT_W-1:0];
            end else if (addr == wsq_pkg::OFS_CMPL_T) begin
                n.cmpl_t = wdata[CNT_W-1:0];
            end else if (addr == wsq_pkg::OFS_ADJ_T) begin
                n.adj_t = wdata[CNT_W-1:0];
            end else if (addr == wsq_pkg::OFS_JCOUNT) begin
                n.jcount = wdata[wsq_pkg::JCNT_W-1:0];
            end
        end

        if (rd_stb) begin
            if (addr == wsq_pkg::OFS_CTRL) begin
                n.rdata[wsq_pkg::CTRL_W-1:0] = r.ctrl;
            end else if (addr == wsq_pkg::OFS_FINAL) begin
                n.rdata[WGT_W-1:0] = r.fin;
            end else if (addr == wsq_pkg::OFS_SP1) begin
                n.rdata[WGT_W-1:0] = r.sp1;
            end else if (addr == wsq_pkg::OFS_SP2) begin
                n.rdata[WGT_W-1:0] = r.sp2;
            end else if (addr == wsq_pkg::OFS_CPS) begin
                n.rdata[WGT_W-1:0] = r.fall_compensation_value;
            end else if (addr == wsq_pkg::OFS_OVER) begin
                n.rdata[WGT_W-1:0] = r.ovr;
            end else if (addr == wsq_pkg::OFS_UNDER) begin
                n.rdata[WGT_W-1:0] = r.und;
            end else if (addr == wsq_pkg::OFS_NEAR) begin
                n.rdata[WGT_W-1:0] = r.nzl;
            end else if (addr == wsq_pkg::OFS_INHIB_T) begin
                n.rdata[CNT_W-1:0] = r.inhib_t;
            end else if (addr == wsq_pkg::OFS_JUDGE_T) begin
                n.rdata[CNT_W-1:0] = r.judge_t;
            end else if (addr == wsq_pkg::OFS_CMPL_T) begin
                n.rdata[CNT_W-1:0] = r.cmpl_t;
            end else if (addr == wsq_pkg::OFS_ADJ_T) begin
                n.rdata[CNT_W-1:0] = r.adj_t;
            end else if (addr == wsq_pkg::OFS_JCOUNT) begin
                n.rdata[wsq_pkg::JCNT_W-1:0] = r.jcount;
            end else if (addr == wsq_pkg::OFS_STATUS) begin
                n.rdata[wsq_pkg::STAT_GATES +: 3] = r.gates;
                n.rdata[wsq_pkg::STAT_NZ] = r.nz;
                n.rdata[wsq_pkg::STAT_JUDGE +: 3] = r.judge;
                n.rdata[wsq_pkg::STAT_CMPL] = r.cmpl;
                n.rdata[wsq_pkg::STAT_ADJ] = r.adj;
                n.rdata[wsq_pkg::STAT_ERR] = r.err;
                n.rdata[wsq_pkg::STAT_STATE +: 3] = r.st;
            end
        end

        if (!seq_mode) begin
            if (r.inhib == '0) begin
                n.gates = '{first: hit1, second: hit2, final_g: hit3};
            end
            if (judge_none) begin
                n.judge = '0;
            end else if (!r.ctrl[wsq_pkg::CTRL_OU_HELD]) begin
                n.judge = judge_of(cw_x, lim_over, lim_under);
            end
            case (r.st)
                wsq_pkg::ST_IDLE: begin
                    if (r.gates.final_g) begin
                        if (judge_none || r.ctrl[wsq_pkg::CTRL_CMPL_FAST]) begin
                            n.st = wsq_pkg::ST_CMPL;
                            n.tmr = r.cmpl_t;
                            n.held = cw_x[WGT_W-1:0];
                            // Held mode must still latch on the fast path
                            if (r.ctrl[wsq_pkg::CTRL_OU_HELD] && !judge_none) begin
                                n.judge = judge_of(cw_x, lim_over, lim_under);
                            end
                        end else begin
                            n.st = wsq_pkg::ST_JUDGE;
                            n.tmr = r.judge_t;
                        end
                    end
                end
                wsq_pkg::ST_JUDGE: begin
                    if (tdone) begin
                        n.st = wsq_pkg::ST_CMPL;
                        n.tmr = r.cmpl_t;
                        n.held = cw_x[WGT_W-1:0];
                        if (r.ctrl[wsq_pkg::CTRL_OU_HELD] && !judge_none) begin
                            n.judge = judge_of(cw_x, lim_over, lim_under);
                        end
                    end
                end
                wsq_pkg::ST_CMPL: begin
                    if (tdone) begin
                        n.st = wsq_pkg::ST_REARM;
                    end
                end
                wsq_pkg::ST_REARM: begin
                    if (below_quarter) begin
                        n.st = wsq_pkg::ST_IDLE;
                    end
                end
                default: begin
                    n.st = wsq_pkg::ST_IDLE;
                end
            endcase
        end else begin
            case (r.st)
                wsq_pkg::ST_IDLE: begin
                    // Gate and judgment comparisons are idle until a start edge
                    if (start_rise && !stop_in) begin
                        n.gates = '1;
                        n.judge = '0;
                        n.st = wsq_pkg::ST_FEED;
                    end
                end
                wsq_pkg::ST_FEED: begin
                    if (r.inhib == '0) begin
                        if (hit1) begin
                            n.gates.first = 1'b0;
                        end
                        if (hit2) begin
                            n.gates.second = 1'b0;
                        end
                        if (hit3) begin
                            n.gates.final_g = 1'b0;
                            if (judge_none || r.ctrl[wsq_pkg::CTRL_CMPL_FAST]) begin
                                n.st = wsq_pkg::ST_CMPL;
                                n.tmr = r.cmpl_t;
                                n.held = cw_x[WGT_W-1:0];
                                if (!judge_none) begin
                                    n.judge = judge_of(cw_x, lim_over, lim_under);
                                end
                            end else begin
                                n.st = wsq_pkg::ST_JUDGE;
                                n.tmr = r.judge_t;
                            end
                        end
                    end
                end
                wsq_pkg::ST_JUDGE: begin
                    if (tdone) begin
                        n.st = wsq_pkg::ST_CMPL;
                        n.tmr = r.cmpl_t;
                        n.held = cw_x[WGT_W-1:0];
                        n.judge = judge_of(cw_x, lim_over, lim_under);
                    end
                end
                wsq_pkg::ST_CMPL: begin
                    if (tdone) begin
                        if (r.ctrl[wsq_pkg::CTRL_ADJ_EN]) begin
                            n.st = wsq_pkg::ST_ADJ;
                            n.tmr = r.adj_t;
                        end else begin
                            n.st = wsq_pkg::ST_IDLE;
                        end
                    end
                end
                wsq_pkg::ST_ADJ: begin
                    if (tdone) begin
                        n.st = wsq_pkg::ST_IDLE;
                    end
                end
                wsq_pkg::ST_ERR: begin
                    if (stop_rise) begin
                        n.st = wsq_pkg::ST_IDLE;
                    end
                end
                default: begin
                    n.st = wsq_pkg::ST_IDLE;
                end
            endcase
            if (stop_in && r.st != wsq_pkg::ST_ERR && n.st != wsq_pkg::ST_ERR) begin
                n.st = wsq_pkg::ST_IDLE;
            end
            if (start_rise && stop_in) begin
                n.st = wsq_pkg::ST_ERR;
                n.gates = '0;
            end
        end

        // Old judgments must not outlive a switch to no judgment
        if (judge_none) begin
            n.judge = '0;
        end
        if (stop_in) begin
            n.gates = '0;
        end
        if (n.gates != r.gates) begin
            n.inhib = r.inhib_t;
        end
        n.cmpl = n.st == wsq_pkg::ST_CMPL;
        n.adj = n.st == wsq_pkg::ST_ADJ;
        n.err = n.st == wsq_pkg::ST_ERR;
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r <= R_RST;
        end else begin
            r <= n;
        end
    end

    assign rdata = r.rdata;
    assign first_gate_output = r.gates.first;
    assign second_gate_output = r.gates.second;
    assign final_gate_output = r.gates.final_g;
    assign near_empty_flag = r.nz;
    assign over_out = r.judge.over;
    assign go_out = r.judge.go;
    assign under_out = r.judge.under;
    assign complete_out = r.cmpl;
    assign adjust_out = r.adj;
    assign seq_error = r.err;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_sync_n);

    property p_near_zero;
        (nzw_x <= sx(r.nzl)) |=> near_empty_flag;
    endproperty
    a_near_zero: assert property (p_near_zero) else $error("near-empty missed");

    property p_start_opens;
        (seq_mode && r.st == wsq_pkg::ST_IDLE && start_rise && !stop_in)
            |=> (first_gate_output && second_gate_output && final_gate_output);
    endproperty
    a_start_opens: assert property (p_start_opens) else $error("gates not opened");

    property p_stop_closes;
        stop_in |=> !(first_gate_output || second_gate_output || final_gate_output);
    endproperty
    a_stop_closes: assert property (p_stop_closes) else $error("stop left a gate open");

    property p_seq_err;
        (seq_mode && start_rise && stop_in) |=> seq_error ##1 (seq_error || stop_rise);
    endproperty
    a_seq_err: assert property (p_seq_err) else $error("sequence error not raised");

    property p_over_go_excl;
        !(over_out && go_out);
    endproperty
    a_over_go_excl: assert property (p_over_go_excl) else $error("over and go together");

    property p_no_judge;
        (judge_none && $past(judge_none)) |=> !(over_out || go_out || under_out);
    endproperty
    a_no_judge: assert property (p_no_judge) else $error("judgment while disabled");

    property p_cmpl_on_close;
        (seq_mode && judge_none && r.st == wsq_pkg::ST_FEED && r.inhib == '0 && hit3 && !stop_in
            && !start_rise) |=> ($fell(final_gate_output) && $rose(complete_out));
    endproperty
    a_cmpl_on_close: assert property (p_cmpl_on_close) else $error("complete not at close");

    property p_busy_ignores_start;
        (seq_mode && r.st == wsq_pkg::ST_CMPL && !tdone && start_rise && !stop_in)
            |=> (complete_out && !first_gate_output);
    endproperty
    a_busy_ignores_start: assert property (p_busy_ignores_start) else $error("start not ignored");

    property p_inhibit_holds;
        (seq_mode && r.st == wsq_pkg::ST_FEED && r.inhib != '0 && !stop_in && !start_rise)
            |=> $stable(r.gates);
    endproperty
    a_inhibit_holds: assert property (p_inhibit_holds) else $error("gate moved in inhibit");

    property p_rearm;
        (!seq_mode && r.st == wsq_pkg::ST_REARM && !below_quarter) |=> (r.st != wsq_pkg::ST_IDLE);
    endproperty
    a_rearm: assert property (p_rearm) else $error("rearmed above quarter");

    c_seq_cycle: cover property (seq_mode && $rose(complete_out));
    c_adjust: cover property ($rose(adjust_out));
    c_error: cover property ($rose(seq_error) ##[1:50] $fell(seq_error));
    c_simple: cover property (!seq_mode && $rose(over_out));

endmodule : wsq_sequencer

`default_nettype wire

// >>> tb/testbench.sv
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_count++; \
    $display("wrong value %s expected %0h seen %0h", n, e, s); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, rst_n = 0, wr_stb = 0, rd_stb = 0, start_in = 0, stop_in = 0, ramp = 0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [23:0] gross_weight, net_weight, set_w = '0;
    logic first_gate_output, second_gate_output, final_gate_output, near_empty_flag;
    logic over_out, go_out, under_out, complete_out, adjust_out, seq_error;
    logic [6:0] outs;
    int err_count = 0, n_checks = 0;
    assign outs = {first_gate_output, second_gate_output, final_gate_output, near_empty_flag,
        over_out, go_out, under_out};
    always #50 clock = ~clock;
    wsq_sequencer dut (.clock, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
        .gross_weight, .net_weight, .start_in, .stop_in, .first_gate_output,
        .second_gate_output, .final_gate_output, .near_empty_flag, .over_out, .go_out,
        .under_out, .complete_out, .adjust_out, .seq_error);
    wsq_valve_model far (.clock, .rst_n, .first(first_gate_output),
        .second(second_gate_output), .final_g(final_gate_output), .ramp, .set_w,
        .gross_weight, .net_weight);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 `CHK("rdata", e, rdata)
    endtask : rd
    task automatic settle;
        repeat (4) @(posedge clock);
        #1;
    endtask : settle
    task automatic kick;
        @(posedge clock);
        start_in <= 1'b1;
        @(posedge clock);
        start_in <= 1'b0;
    endtask : kick
    // Final 1000, offsets 300/100, fall 20, tolerances 10/10, near 50
    function automatic logic [6:0] ref_out(input int w, input int g);
        return {w >= 700, w >= 900, w >= 980, g <= 50, w > 1010, w >= 990 && w <= 1010, w <= 990};
    endfunction : ref_out
    task automatic setup(input logic [31:0] ctrl, input logic [31:0] jc);
        int v[11] = '{1000, 300, 100, 20, 10, 10, 50, 0, 2, 4, 3};
        for (int i = 0; i < 11; i++) wr(8'(4 * i + 4), 32'(v[i]));
        wr(wsq_pkg::OFS_JCOUNT, jc);
        wr(wsq_pkg::OFS_CTRL, ctrl);
        settle;
    endtask : setup
    task automatic count_hi(input int len, output int c, output int a, output int f);
        c = 0;
        a = 0;
        f = 99;
        for (int i = 0; i < len; i++) begin
            if (complete_out && f == 99) f = i;
            c += complete_out;
            a += adjust_out;
            @(posedge clock);
            #1;
        end
    endtask : count_hi
    task automatic t_regs;
        rd(wsq_pkg::OFS_CTRL, 32'h0000_0000);
        rd(wsq_pkg::OFS_JCOUNT, 32'h0000_0001);
        wr(wsq_pkg::OFS_FINAL, 32'hFF00_03E8);
        rd(wsq_pkg::OFS_FINAL, 32'h0000_03E8);
        wr(8'h3C, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h0000_0000);
    endtask : t_regs
    task automatic t_simple;
        int w[11] = '{50, 51, 699, 700, 899, 900, 979, 980, 990, 1010, 1011};
        setup(32'h0000_0000, 32'h0000_0001);
        foreach (w[i]) begin
            set_w <= 24'(w[i]);
            settle;
            `CHK("simple", ref_out(w[i], w[i]), outs)
        end
        wr(wsq_pkg::OFS_CTRL, 32'h0000_0004);
        set_w <= 24'd1080;
        settle;
        `CHK("net compare", ref_out(980, 1080), outs)
        wr(wsq_pkg::OFS_CTRL, 32'h0000_0006);
        set_w <= 24'd150;
        settle;
        `CHK("net near", ref_out(50, 50), outs)
    endtask : t_simple
    task automatic t_rearm;
        int c, a, f;
        setup(32'h0000_0000, 32'h0000_0001);
        set_w <= 24'd980;
        count_hi(16, c, a, f);
        set_w <= 24'd300;
        settle;
        set_w <= 24'd980;
        count_hi(16, c, a, f);
        `CHK("no rearm", 0, c)
        set_w <= 24'd249;
        settle;
        set_w <= 24'd980;
        count_hi(16, c, a, f);
        `CHK("rearmed", 4, c)
        wr(wsq_pkg::OFS_CTRL, 32'h0000_0010);
        set_w <= 24'd1011;
        settle;
        `CHK("held judge", 3'b001, outs[2:0])
        set_w <= 24'd200;
        settle;
        set_w <= 24'd1011;
        repeat (2) settle;
        `CHK("judged at complete", 3'b100, outs[2:0])
        wr(wsq_pkg::OFS_CTRL, 32'h0000_0030);
        set_w <= 24'd200;
        settle;
        set_w <= 24'd1000;
        count_hi(16, c, a, f);
        `CHK("fast complete", 3, f)
        `CHK("fast judge", 3'b010, outs[2:0])
    endtask : t_rearm
    task automatic t_seq;
        int n = 0;
        setup(32'h0000_0001, 32'h0000_0001);
        set_w <= 24'd1000;
        @(posedge clock) stop_in <= 1'b1;
        @(posedge clock) stop_in <= 1'b0;
        settle;
        `CHK("idle gates", 3'b000, outs[6:4])
        set_w <= '0;
        settle;
        ramp <= 1'b1;
        kick;
        repeat (2) @(posedge clock);
        #1 `CHK("gates open", 3'b111, outs[6:4])
        while (!complete_out && n < 300) begin
            @(posedge clock);
            #1 n++;
        end
        // Feed stops near 982, so the held weight must judge under
        `CHK("judged", 4'b0001, {outs[4], outs[2:0]})
        kick;
        settle;
        `CHK("late start", 3'b000, outs[6:4])
    endtask : t_seq
    task automatic t_stop;
        ramp <= 1'b0;
        settle;
        kick;
        settle;
        `CHK("gates", 3'b111, outs[6:4])
        @(posedge clock) stop_in <= 1'b1;
        settle;
        `CHK("stopped", 3'b000, outs[6:4])
        kick;
        settle;
        `CHK("error", 1'b1, seq_error)
        @(posedge clock) stop_in <= 1'b0;
        settle;
        @(posedge clock) stop_in <= 1'b1;
        settle;
        `CHK("cleared", 1'b0, seq_error)
        @(posedge clock) stop_in <= 1'b0;
    endtask : t_stop
    task automatic t_nojudge;
        int n = 0, c, a, f;
        setup(32'h0000_0009, 32'h0000_0000);
        ramp <= 1'b1;
        kick;
        settle;
        while (final_gate_output && n < 300) begin
            @(posedge clock);
            #1 n++;
        end
        count_hi(16, c, a, f);
        `CHK("complete lag", 1'b1, f <= 2)
        `CHK("complete len", 4, c)
        `CHK("adjust len", 3, a)
        `CHK("no judgment", 3'b000, outs[2:0])
    endtask : t_nojudge
    task automatic complete_run;
        if (err_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    initial begin
        #1000000;
        err_count++;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_regs;
        t_simple;
        t_rearm;
        t_seq;
        t_stop;
        t_nojudge;
        complete_run;
    end
endmodule : testbench
`default_nettype wire

// >>> tb/wsq_valve_model.sv
`default_nettype none
module wsq_valve_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic first,
    input wire logic second,
    input wire logic final_g,
    input wire logic ramp,
    input wire logic [23:0] set_w,
    output logic [23:0] gross_weight,
    output logic [23:0] net_weight
);
    timeunit 1ns;
    timeprecision 1ns;
    // Flow drops as gates close, so the fine stage overshoots by one step
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) gross_weight <= '0;
        else if (!ramp) gross_weight <= set_w;
        else if (first) gross_weight <= gross_weight + 24'h00_0028;
        else if (second) gross_weight <= gross_weight + 24'h00_000A;
        else if (final_g) gross_weight <= gross_weight + 24'h00_0002;
    end
    // Fixed tare so gross and net never agree
    assign net_weight = gross_weight - 24'h00_0064;
endmodule : wsq_valve_model
`default_nettype wire
